// ===== src/imc_pkg.sv
// shared constants and types for the input measurement conditioning block
package imc_pkg;
  // ===========================================================
  // channel count and timing
  localparam int NCH = 8;
  localparam int CLK_FREQ_HZ = 25_000_000;         // aclk rate
  localparam int SLOT_TIME_MS = 1;                 // one scan slot
  localparam int NORMAL_PERIOD_MS = 9;             // fixed scan period
  localparam int CYC_PER_MS_DEF = CLK_FREQ_HZ / 1000 * SLOT_TIME_MS;
  localparam logic [3:0] NORMAL_LAST_SLOT = 4'(NORMAL_PERIOD_MS / SLOT_TIME_MS - 1);

  // ===========================================================
  // register map (byte addresses)
  localparam int ADDR_W = 9;
  localparam logic [8:0] REG_CTRL = 9'h000;        // bit0 scan enable, bit1 fast mode
  localparam logic [8:0] REG_ACTIVE = 9'h004;      // channels in use mask
  localparam logic [8:0] REG_STATUS = 9'h008;      // completed scan count
  localparam logic [4:0] CH_CFG = 5'h00;           // per-channel configuration
  localparam logic [4:0] CH_THR = 5'h04;           // lower [15:0], upper [31:16] thresholds
  localparam logic [4:0] CH_USR = 5'h08;           // user scale lower [15:0], upper [31:16]
  localparam logic [4:0] CH_ALIGN = 5'h0c;         // alignment offset
  localparam logic [4:0] CH_VALUE = 5'h10;         // latest result, read only
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FAST_BIT = 1;

  // ===========================================================
  // values after reset
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam logic [7:0] ACTIVE_RST = 8'hff;
  localparam logic [7:0] CFG_RST = 8'h81;          // checking on, 0..10 V, no filter
  localparam logic [31:0] THR_RST = 32'h2af8_fc18; // upper 11000, lower -1000
  localparam logic [31:0] USR_RST = 32'h2710_0000; // upper 10000, lower 0

  // ===========================================================
  // measurement limits
  localparam logic signed [15:0] NOM_MAX = 16'sh2710;     // 10000
  localparam logic signed [15:0] BIP_MIN = -16'sh2710;    // -10000
  localparam logic signed [15:0] UNI_MIN = 16'sh0000;
  localparam logic signed [15:0] ALIGN_LIM = 16'sh05dc;   // 1500
  localparam logic signed [15:0] S16_MAX = 16'sh7fff;
  localparam logic signed [15:0] S16_MIN = 16'sh8000;
  localparam logic [2:0] FILT_MAX = 3'h6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ===========================================================
  // types
  typedef enum logic [2:0] {
    RNG_BIP_10V, RNG_UNI_10V, RNG_UNI_5V, RNG_UNI_0_20MA, RNG_UNI_4_20MA, RNG_BIP_5V
  } imc_range_type;

  typedef struct packed {
    logic ovf_en;          // overflow/underflow checking
    logic user_scale;      // user-defined display
    logic [2:0] filt;      // filter setting 0..6
    logic [2:0] range;     // input range code
  } imc_cfg_type;

  typedef struct packed {
    logic aligned;         // alignment offset applied
    logic lo_tol;          // lower tolerance area
    logic hi_tol;          // upper tolerance area
    logic undf;            // underflow
    logic ovf;             // overflow
    logic [15:0] value;    // reported value
  } imc_result_type;
endpackage

// ===== src/imc_input_conditioning.sv
// eight-channel measurement scheduler and post-processing with axi4-lite registers
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps

// Notes on behaviour
// - normal mode scans every 9 ms fixed
// - fast mode: active channels only, 1+N ms
// - scan runs free; host reads latest values
// - six input ranges selectable per channel
// - tolerance areas always detected on all channels
// - above upper threshold overflow, below lower underflow
// - range maximum to upper threshold: upper tolerance
// - range minimum to lower threshold: lower tolerance
// - independent integer thresholds, 0-10 V defaults
// - unipolar standardized display spans 0 to 10000
// - bipolar standardized display spans -10000 to 10000
// - user display maps range linearly to limits
// - recursive first-order filter on each channel
// - filter setting 0..6, changeable while running
// - settings map to alpha by power-of-two shifts
// - filtering works in both scan modes
// - per-channel alignment offset, writable anytime, added
// - alignment offset limited to plus/minus 1500
// - readable flag shows alignment applied
// - alignment leaves range, scan, filter untouched
// - order: alignment, then filter, then scaling
module imc_input_conditioning
  import imc_pkg::*;
#(
  parameter int CYC_PER_MS = CYC_PER_MS_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic conv_start,
  output logic [2:0] conv_chan,
  output imc_range_type conv_range,
  input wire logic sample_valid,
  input wire logic [2:0] sample_chan,
  input wire logic signed [15:0] sample_data
);

  // ===========================================================
  // helper functions

  // merge written bytes into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (old & ~m) | (d & m);
  endfunction

  // clip a wide signed value into 16 bits
  function automatic logic [15:0] sat16(input logic signed [35:0] v);
    if (v > 36'(S16_MAX)) begin
      return S16_MAX;
    end else if (v < 36'(S16_MIN)) begin
      return S16_MIN;
    end else begin
      return v[15:0];
    end
  endfunction

  // first set bit of mask at or above start
  function automatic logic [3:0] first_from(input logic [7:0] mask, input logic [3:0] start);
    logic [3:0] r;
    r = 4'h8;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (mask[i] && (4'(i) >= start)) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // ===========================================================
  // register storage
  logic [1:0] ctrl_r;                    // scan enable and mode
  logic [1:0] ctrl_nxt;
  logic [7:0] active_r;                  // channels in use
  logic [7:0] active_nxt;
  logic [15:0] scan_cnt_r;               // completed scans
  logic [15:0] scan_cnt_nxt;
  imc_cfg_type cfg_r [NCH];              // channel configuration
  logic [31:0] thr_r [NCH];              // channel thresholds
  logic [31:0] usr_r [NCH];              // user display limits
  logic signed [15:0] align_r [NCH];     // alignment offsets
  logic signed [15:0] filt_r [NCH];      // filter memory
  logic [NCH-1:0] primed_r;              // filter memory holds a sample
  imc_result_type res_r [NCH];           // latest results

  // ===========================================================
  // axi4-lite write channel
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;
  logic wr_fire;                         // address and data taken together
  logic wr_glob;
  logic wr_ok;
  logic [2:0] wr_ch;
  logic [4:0] wr_off;
  logic [8:0] wr_a;

  assign awready = awvalid && wvalid && !bvalid_r;
  assign wready = awvalid && wvalid && !bvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;

  // write address decode
  always_comb begin
    wr_fire = awvalid && wvalid && !bvalid_r;
    wr_a = {awaddr[8:2], 2'b00};
    wr_glob = !awaddr[8];
    wr_ch = awaddr[7:5];
    wr_off = {awaddr[4:2], 2'b00};
    if (wr_glob) begin
      wr_ok = (wr_a == REG_CTRL) || (wr_a == REG_ACTIVE) || (wr_a == REG_STATUS);
    end else begin
      wr_ok = (wr_off <= CH_VALUE);
    end
  end

  // write response and global registers
  always_comb begin
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    ctrl_nxt = ctrl_r;
    active_nxt = active_r;
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (wr_fire) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_ok ? RESP_OKAY : RESP_SLVERR;
      if (wr_glob && wr_a == REG_CTRL) begin
        ctrl_nxt = 2'(merge(32'(ctrl_r), wdata, wstrb));
      end
      if (wr_glob && wr_a == REG_ACTIVE) begin
        active_nxt = 8'(merge(32'(active_r), wdata, wstrb));
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      ctrl_r <= CTRL_RST;
      active_r <= ACTIVE_RST;
    end else begin
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      ctrl_r <= ctrl_nxt;
      active_r <= active_nxt;
    end
  end

  // ===========================================================
  // axi4-lite read channel
  logic rvalid_r;
  logic rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;
  logic [8:0] rd_a;
  logic [2:0] rd_ch;

  assign arready = !rvalid_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // read mux, latched when the address is taken
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    rd_a = {araddr[8:2], 2'b00};
    rd_ch = araddr[7:5];
    if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    if (arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      if (!araddr[8]) begin
        if (rd_a == REG_CTRL) begin
          rdata_nxt = 32'(ctrl_r);
        end else if (rd_a == REG_ACTIVE) begin
          rdata_nxt = 32'(active_r);
        end else if (rd_a == REG_STATUS) begin
          rdata_nxt = 32'(scan_cnt_r);
        end else begin
          rresp_nxt = RESP_SLVERR;
        end
      end else begin
        unique case ({araddr[4:2], 2'b00})
          CH_CFG: rdata_nxt = 32'(cfg_r[rd_ch]);
          CH_THR: rdata_nxt = thr_r[rd_ch];
          CH_USR: rdata_nxt = usr_r[rd_ch];
          CH_ALIGN: rdata_nxt = {{16{align_r[rd_ch][15]}}, align_r[rd_ch]};
          // results stay readable at any time, unsynchronised to the scan
          // latest value read
          CH_VALUE: rdata_nxt = 32'(res_r[rd_ch]);
          default: rresp_nxt = RESP_SLVERR;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // ===========================================================
  // scan scheduler
  localparam int MS_W = $clog2(CYC_PER_MS);
  logic [MS_W-1:0] ms_cnt_r;             // divider to 1 ms slots
  logic [MS_W-1:0] ms_cnt_nxt;
  logic [3:0] slot_r;                    // slot inside the period
  logic [3:0] slot_nxt;
  logic [3:0] ptr_r;                     // fast mode search start
  logic [3:0] ptr_nxt;
  logic conv_start_r;
  logic conv_start_nxt;
  logic [2:0] conv_chan_r;
  logic [2:0] conv_chan_nxt;
  imc_range_type conv_range_r;
  imc_range_type conv_range_nxt;
  logic ms_tick;
  logic [3:0] hit;
  logic [3:0] after;

  assign conv_start = conv_start_r;
  assign conv_chan = conv_chan_r;
  assign conv_range = conv_range_r;

  // slot sequencing and conversion requests
  always_comb begin
    ms_tick = (ms_cnt_r == MS_W'(CYC_PER_MS - 1));
    ms_cnt_nxt = ms_tick ? '0 : ms_cnt_r + 1'b1;
    slot_nxt = slot_r;
    ptr_nxt = ptr_r;
    scan_cnt_nxt = scan_cnt_r;
    conv_start_nxt = 1'b0;
    conv_chan_nxt = conv_chan_r;
    conv_range_nxt = conv_range_r;
    hit = first_from(active_r, ptr_r);
    after = first_from(active_r, hit + 4'h1);
    if (!ctrl_r[CTRL_EN_BIT]) begin
      slot_nxt = 4'h0;
      ptr_nxt = 4'h0;
    end else if (ms_tick && !ctrl_r[CTRL_FAST_BIT]) begin
      if (slot_r < 4'(NCH) && active_r[slot_r[2:0]]) begin
        conv_start_nxt = 1'b1;
        conv_chan_nxt = slot_r[2:0];
        conv_range_nxt = imc_range_type'(cfg_r[slot_r[2:0]].range);
      end
      slot_nxt = (slot_r >= NORMAL_LAST_SLOT) ? 4'h0 : slot_r + 4'h1;
      if (slot_r >= NORMAL_LAST_SLOT) begin
        scan_cnt_nxt = scan_cnt_r + 16'h0001;
      end
    end else if (ms_tick) begin
      if (slot_r == 4'h0) begin
        ptr_nxt = 4'h0;
        slot_nxt = (first_from(active_r, 4'h0) == 4'h8) ? 4'h0 : 4'h1;
        if (first_from(active_r, 4'h0) == 4'h8) begin
          scan_cnt_nxt = scan_cnt_r + 16'h0001;
        end
      end else if (hit == 4'h8) begin
        slot_nxt = 4'h0;
        scan_cnt_nxt = scan_cnt_r + 16'h0001;
      end else begin
        conv_start_nxt = 1'b1;
        conv_chan_nxt = hit[2:0];
        conv_range_nxt = imc_range_type'(cfg_r[hit[2:0]].range);
        ptr_nxt = hit + 4'h1;
        slot_nxt = (after == 4'h8) ? 4'h0 : 4'h1;
        if (after == 4'h8) begin
          scan_cnt_nxt = scan_cnt_r + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_cnt_r <= '0;
      slot_r <= 4'h0;
      ptr_r <= 4'h0;
      scan_cnt_r <= 16'h0000;
      conv_start_r <= 1'b0;
      conv_chan_r <= 3'h0;
      conv_range_r <= RNG_UNI_10V;
    end else begin
      ms_cnt_r <= ms_cnt_nxt;
      slot_r <= slot_nxt;
      ptr_r <= ptr_nxt;
      scan_cnt_r <= scan_cnt_nxt;
      conv_start_r <= conv_start_nxt;
      conv_chan_r <= conv_chan_nxt;
      conv_range_r <= conv_range_nxt;
    end
  end

  // ===========================================================
  // sample processing datapath
  imc_cfg_type cs;                       // configuration of sampled channel
  logic signed [15:0] rmin;              // range minimum in display units
  logic signed [15:0] corr;              // aligned sample
  logic signed [15:0] f_new;             // filtered sample
  logic signed [17:0] fdiff;
  logic [2:0] shift;
  logic signed [15:0] thr_lo;
  logic signed [15:0] thr_hi;
  logic signed [35:0] d_in;
  logic signed [35:0] d_usr;
  logic signed [35:0] prod;
  logic signed [35:0] span;
  logic signed [35:0] scaled;
  imc_result_type res_new;

  always_comb begin
    cs = cfg_r[sample_chan];
    rmin = (cs.range == RNG_BIP_10V || cs.range == RNG_BIP_5V) ? BIP_MIN : UNI_MIN;
    corr = sat16(36'(sample_data) + 36'(align_r[sample_chan]));
    shift = (cs.filt == 3'h0) ? 3'h0 : cs.filt + 3'h1;
    fdiff = 18'(corr) - 18'(filt_r[sample_chan]);
    if (!primed_r[sample_chan] || shift == 3'h0) begin
      f_new = corr;
    end else begin
      f_new = 16'(18'(filt_r[sample_chan]) + (fdiff >>> shift));
    end
    thr_lo = thr_r[sample_chan][15:0];
    thr_hi = thr_r[sample_chan][31:16];
    res_new.ovf = cs.ovf_en && (f_new > thr_hi);
    res_new.undf = cs.ovf_en && (f_new < thr_lo);
    res_new.hi_tol = (f_new > NOM_MAX) && (f_new <= thr_hi);
    res_new.lo_tol = (f_new < rmin) && (f_new >= thr_lo);
    res_new.aligned = (align_r[sample_chan] != 16'sh0000);
    d_in = 36'(f_new) - 36'(rmin);
    d_usr = 36'($signed(usr_r[sample_chan][31:16])) - 36'($signed(usr_r[sample_chan][15:0]));
    prod = d_in * d_usr;
    span = 36'(NOM_MAX) - 36'(rmin);
    scaled = 36'($signed(usr_r[sample_chan][15:0])) + prod / span;
    res_new.value = cs.user_scale ? sat16(scaled) : f_new;
  end

  // ===========================================================
  // per-channel storage
  logic [31:0] cfg_w;
  logic signed [15:0] al_w;

  // clipped values of a channel write
  always_comb begin
    cfg_w = merge(32'(cfg_r[wr_ch]), wdata, wstrb);
    al_w = 16'(merge(32'(align_r[wr_ch]), wdata, wstrb));
    if (al_w > ALIGN_LIM) begin
      al_w = ALIGN_LIM;
    end else if (al_w < -ALIGN_LIM) begin
      al_w = -ALIGN_LIM;
    end
    // settings above 6 read as 6
    if (cfg_w[5:3] > FILT_MAX) begin
      cfg_w[5:3] = FILT_MAX;
    end
    if (cfg_w[2:0] > 3'(RNG_BIP_5V)) begin
      cfg_w[2:0] = cfg_r[wr_ch].range;
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic wr_me;
    logic smp_me;
    assign wr_me = wr_fire && !wr_glob && (wr_ch == 3'(g));
    assign smp_me = sample_valid && (sample_chan == 3'(g));

    // configuration and results of one channel
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cfg_r[g] <= CFG_RST;
        thr_r[g] <= THR_RST;
        usr_r[g] <= USR_RST;
        align_r[g] <= 16'sh0000;
        filt_r[g] <= 16'sh0000;
        primed_r[g] <= 1'b0;
        res_r[g] <= '0;
      end else begin
        if (wr_me && wr_off == CH_CFG) begin
          cfg_r[g] <= imc_cfg_type'(cfg_w[7:0]);
        end
        if (wr_me && wr_off == CH_THR) begin
          thr_r[g] <= merge(thr_r[g], wdata, wstrb);
        end
        if (wr_me && wr_off == CH_USR) begin
          usr_r[g] <= merge(usr_r[g], wdata, wstrb);
        end
        if (wr_me && wr_off == CH_ALIGN) begin
          align_r[g] <= al_w;
        end
        if (smp_me) begin
          filt_r[g] <= f_new;
          primed_r[g] <= 1'b1;
          res_r[g] <= res_new;
        end
      end
    end
  end

endmodule

// ===== sim/imc_conv_model.sv
// converter partner model answering conversion requests
`timescale 1ns/1ps
module imc_conv_model
  import imc_pkg::*;
(
  input wire logic aclk,
  input wire logic conv_start,
  input wire logic [2:0] conv_chan,
  input wire imc_range_type conv_range,
  input wire logic [3:0] lag,
  input wire logic [7:0][15:0] tab,
  output logic sample_valid,
  output logic [2:0] sample_chan,
  output logic signed [15:0] sample_data
);
  logic busy_r = 1'b0; // conversion under way
  logic [3:0] cnt_r = 4'h0; // cycles left before the answer
  initial sample_valid = 1'b0;
  initial sample_chan = 3'h0;
  initial sample_data = 16'h0000;
  // ===================================
  // conversion timing
  // answer lag+1 cycles after taking the request; the data line toggles in all other cycles
  always @(posedge aclk) begin
    sample_valid <= 1'b0;
    sample_data <= ~sample_data;
    if (conv_start) begin
      busy_r <= 1'b1;
      cnt_r <= lag;
      sample_chan <= conv_chan;
    end else if (busy_r && cnt_r == 4'h0) begin
      busy_r <= 1'b0;
      sample_valid <= 1'b1;
      sample_data <= tab[sample_chan];
    end else if (busy_r) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule

// ===== sim/imc_input_conditioning_assertions.sv
// port checker for the input measurement conditioning block
`timescale 1ns/1ps
module imc_input_conditioning_assertions
  import imc_pkg::*;
#(
  parameter int CYC_PER_MS = CYC_PER_MS_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic conv_start,
  input wire logic [2:0] conv_chan,
  input wire imc_range_type conv_range
);
  // ===================================
  // cycles since the last conversion request, modulo one slot
  logic [15:0] gap_r;
  logic [15:0] gap_nxt;
  logic seen_r; // a request was seen since reset
  logic seen_nxt;
  logic aw_bad; // write to the hole in the map
  logic ar_bad; // read from the hole in the map
  assign aw_bad = awaddr[8] ? (awaddr[4:2] > 3'h4) : (awaddr >= 9'h00c);
  assign ar_bad = araddr[8] ? (araddr[4:2] > 3'h4) : (araddr >= 9'h00c);
  // next gap count and seen flag
  always_comb begin
    gap_nxt = conv_start ? 16'h0001 : (gap_r == 16'(CYC_PER_MS - 1)) ? 16'h0000 : gap_r + 16'h0001;
    seen_nxt = seen_r | conv_start;
  end
  // register the helpers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_r <= 16'h0000;
      seen_r <= 1'b0;
    end else begin
      gap_r <= gap_nxt;
      seen_r <= seen_nxt;
    end
  end
  // ===================================
  // properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    awvalid && wvalid && !bvalid;
  endsequence
  sequence s_rd_take;
    arvalid && !rvalid;
  endsequence
  a_wr_answer: assert property (s_wr_take |=> bvalid)
    else $error("write not answered");
  a_wr_refused: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer pending");
  a_wr_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  a_wr_unmapped: assert property (s_wr_take ##0 aw_bad |=> bresp == RESP_SLVERR)
    else $error("hole write not refused");
  a_wr_mapped: assert property (s_wr_take ##0 !aw_bad |=> bresp == RESP_OKAY)
    else $error("mapped write refused");
  a_rd_answer: assert property (s_rd_take |=> rvalid && !arready)
    else $error("read not answered");
  a_rd_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer changed");
  a_rd_unmapped: assert property (s_rd_take ##0 ar_bad |=> rresp == RESP_SLVERR && rdata == 0)
    else $error("hole read not refused");
  a_start_pulse: assert property (conv_start |=> !conv_start [*8])
    else $error("requests too close");
  a_slot_grid: assert property (conv_start && seen_r |-> gap_r == 16'h0000)
    else $error("request off the slot grid");
  a_chan_stands: assert property ($past(aresetn) && !conv_start |-> $stable(conv_chan)
    && $stable(conv_range))
    else $error("channel or range moved");
endmodule
bind imc_input_conditioning imc_input_conditioning_assertions #(
  .CYC_PER_MS(CYC_PER_MS)
) u_imc_input_conditioning_assertions (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready), .conv_start(conv_start), .conv_chan(conv_chan),
  .conv_range(conv_range)
);

// ===== sim/tb_imc_input_conditioning.sv
// self-checking bench for the input measurement conditioning block
`timescale 1ns/1ps
module tb_imc_input_conditioning;
  import imc_pkg::*;
  typedef struct packed {
    logic [7:0] cfg;
    logic [31:0] thr;
    logic [31:0] usr;
    logic [15:0] align;
    logic [15:0] data;
    logic [31:0] exp;
  } imc_row_type;
  // ===================================
  // signals
  logic aclk, awready, wready, bvalid, arready, rvalid, conv_start, sample_valid;
  logic aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [8:0] awaddr = 9'h000, araddr = 9'h000, b;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [2:0] conv_chan, sample_chan;
  imc_range_type conv_range;
  logic signed [15:0] sample_data;
  logic [3:0] lag = 4'h1; // converter answer delay
  logic [7:0][15:0] tab = '0; // converter data per channel
  int errors = 0, cmp_count = 0, cyc = 0, n, k;
  // one channel per row: config, thresholds, user span, offset, sample, result
  imc_row_type rows [8] = '{
    '{8'h81, THR_RST, USR_RST, 16'h0, 16'h2904, 32'h0004_2904},
    '{8'h81, THR_RST, USR_RST, 16'h0, 16'h2cec, 32'h0001_2cec},
    '{8'h81, THR_RST, USR_RST, 16'h0, 16'hfe0c, 32'h0008_fe0c},
    '{8'h01, THR_RST, USR_RST, 16'h0, 16'h2904, 32'h0004_2904},
    '{8'h81, THR_RST, USR_RST, 16'h0, 16'hf830, 32'h0002_f830},
    '{8'hc4, THR_RST, 32'h2580_f380, 16'h0, 16'h1388, 32'h0000_0c80},
    '{8'h81, THR_RST, USR_RST, 16'h0bb8, 16'h7d00, 32'h0011_7fff},
    '{8'h80, 32'h2af8_d508, USR_RST, 16'h0, 16'hd6fc, 32'h0008_d6fc}};
  logic [8:0] ra [6] = '{9'h110, REG_CTRL, REG_ACTIVE, 9'h100, 9'h104, 9'h108};
  logic [31:0] rv [6] = '{32'h0, 32'h1, 32'hff, 32'h81, THR_RST, USR_RST};
  imc_input_conditioning #(.CYC_PER_MS(10)) u_imc_input_conditioning (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .conv_start(conv_start), .conv_chan(conv_chan),
    .conv_range(conv_range), .sample_valid(sample_valid), .sample_chan(sample_chan),
    .sample_data(sample_data));
  imc_conv_model u_imc_conv_model (
    .aclk(aclk), .conv_start(conv_start), .conv_chan(conv_chan), .conv_range(conv_range),
    .lag(lag), .tab(tab), .sample_valid(sample_valid), .sample_chan(sample_chan),
    .sample_data(sample_data));
  // ===================================
  // clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors++;
      tally_and_finish();
    end
  end
  // ===================================
  // bus cycles and checks
  task automatic wr(input logic [8:0] a, input logic [31:0] dd, output logic [1:0] rr);
    @(posedge aclk);
    awaddr <= a;
    wdata <= dd;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(negedge aclk);
    while (!awready) @(negedge aclk);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(negedge aclk);
    while (!bvalid) @(negedge aclk);
    rr = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, output logic [31:0] dd, output logic [1:0] rr);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(negedge aclk);
    while (!arready) @(negedge aclk);
    @(posedge aclk);
    arvalid <= 1'b0;
    @(negedge aclk);
    while (!rvalid) @(negedge aclk);
    dd = rdata;
    rr = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // wait for a request (s=0) or a sample (s=1) of channel c
  task automatic wev(input logic s, input logic [2:0] c);
    @(negedge aclk);
    while (!(s ? sample_valid && sample_chan == c : conv_start && conv_chan == c))
      @(negedge aclk);
  endtask
  // cycles p between channel 0 requests and requests q within them
  task automatic period(output int p, output int q);
    wev(1'b0, 3'h0);
    @(negedge aclk);
    p = 1;
    q = 1;
    while (!(conv_start && conv_chan == 3'h0)) begin
      q += int'(conv_start);
      p++;
      @(negedge aclk);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ===================================
  // main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], d, r);
      chk(d, rv[i]);
    end
    wr(9'h020, 32'h1, r);
    chk(32'(r), 32'(RESP_SLVERR));
    rd(9'h020, d, r);
    chk(d, 32'h0);
    chk(32'(r), 32'(RESP_SLVERR));
    $display("reset and map test done");
    for (int i = 0; i < 8; i++) begin
      b = 9'h100 + 9'(i * 32);
      wr(b, 32'(rows[i].cfg), r);
      wr(b + 9'h4, rows[i].thr, r);
      wr(b + 9'h8, rows[i].usr, r);
      wr(b + 9'hc, {{16{rows[i].align[15]}}, rows[i].align}, r);
      tab[i] <= rows[i].data;
    end
    repeat (200) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      rd(9'h110 + 9'(i * 32), d, r);
      chk(d, rows[i].exp);
    end
    rd(9'h1cc, d, r);
    chk(d, 32'h0000_05dc);
    $display("row test done");
    for (int i = 0; i < 6; i++) begin
      wr(9'h120, 32'h80 + 32'(i), r);
      wev(1'b0, 3'h1);
      chk(32'(conv_range), 32'(i));
    end
    period(n, k);
    chk(32'(n), 32'd90);
    chk(32'(k), 32'd8);
    wr(REG_ACTIVE, 32'h05, r);
    wr(REG_CTRL, 32'h3, r);
    period(n, k);
    chk(32'(n), 32'd30);
    chk(32'(k), 32'd2);
    $display("scan timing test done");
    lag <= 4'h6;
    wr(9'h100, 32'h89, r);
    wev(1'b1, 3'h0);
    tab[0] <= 16'h09c4;
    wev(1'b1, 3'h0);
    rd(9'h110, d, r);
    chk(d, 32'h0000_2134);
    wev(1'b1, 3'h0);
    rd(9'h110, d, r);
    chk(d, 32'h0000_1b58);
    $display("filter test done");
    tally_and_finish();
  end
endmodule
